/* hdl/charger_pkg.sv */
// package: constants, register layouts and carrier types of the charge cycle controller
//
// Operation
// - cycle start picks short, precharge or fast current by battery voltage; phase 01/10.
// - above depletion release, probe remote sense; absent sets remote_sense_disable, uses battery pin.
// - host writing remote_sense_disable 0 above threshold restarts probe; below uses battery pin.
// - above recharge and below termination current ends cycle: pin high, 11, pulse; switch off at once, or after top-off when set.
// - input current, input voltage or thermal regulation suppress termination.
// - termination threshold is the below_term comparator level; termination enable 0 stops termination.
// - top-off timer pauses and slows exactly like the safety timer.
// - top-off keeps indicator high, sets topoff_running_flag, pulses at start and expiry.
// - top-off setting latched at termination; 00 stops a running top-off at once.
// - charging starts only inside cold..hot window; outside, suspend and report fault.
// - cool zone scales fast current by cool_current_scale, default 20 percent.
// - warm zone lowers voltage per warm_voltage_select, scales current, never terminates.
// - thermistor_bypass ignores thermistor and reports thermistor_fault_code 000.
// - safety timer 2 h below low-battery threshold, else 10 or 20 h; enable bit.
// - safety expiry blinks indicator at 1 Hz, sets charge_fault_code 11, pulses.
// - regulation or reduced cool/warm current halves timer rate unless slowdown disabled.
// - suspend faults pause the safety timer; toggling charge enable restarts it.
// - battery_switch_disable turns switch off now or after delay per delay select; with adapter present only if ship_with_input_bit is set.
// - ship mode exits on adapter plug, disable clear, register reset or button press.
// - button held for hold time starts reset: switch off, back on, defaults restored except high_impedance_enable, which is kept.
// - reset_with_input_bit 1 resets at once via high impedance; 0 waits adapter removal.
package charger_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
	localparam int unsigned INT_PULSE_US = 256;
	localparam int unsigned INT_CYCLES_DEF = (CLK_HZ / 1_000_000) * INT_PULSE_US;
	localparam int unsigned PRE_W = 17;
	localparam int unsigned INT_W = 15;
	localparam int unsigned TMR_W = 27;
	localparam int unsigned BTN_W = 16;
	localparam int unsigned ADR_W = 8;
	localparam int unsigned MS_PER_H = 3_600_000;
	localparam int unsigned MS_PER_MIN = 60_000;
	localparam int unsigned SAFETY_LOW_H = 2;
	localparam int unsigned SAFETY_SHORT_H = 10;
	localparam int unsigned SAFETY_LONG_H = 20;
	localparam int unsigned TOPOFF_UNIT_MIN = 15;
	localparam logic [TMR_W-1:0] SAFETY_LOW_MS = TMR_W'(SAFETY_LOW_H * MS_PER_H);
	localparam logic [TMR_W-1:0] SAFETY_SHORT_MS = TMR_W'(SAFETY_SHORT_H * MS_PER_H);
	localparam logic [TMR_W-1:0] SAFETY_LONG_MS = TMR_W'(SAFETY_LONG_H * MS_PER_H);
	localparam logic [TMR_W-1:0] TOPOFF_UNIT_MS = TMR_W'(TOPOFF_UNIT_MIN * MS_PER_MIN);
	localparam logic [BTN_W-1:0] BUTTON_RESET_MS = 16'h2710;
	localparam logic [BTN_W-1:0] SHIP_DEGLITCH_MS = 16'h03E8;
	localparam logic [BTN_W-1:0] SWITCH_DLY_MS = 16'h2710;
	localparam logic [BTN_W-1:0] RESET_OFF_MS = 16'h01F4;
	localparam logic [BTN_W-1:0] BLINK_HALF_MS = 16'h01F4;
	localparam logic [ADR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [ADR_W-1:0] CFG_OFS = 8'h04;
	localparam logic [ADR_W-1:0] STATUS_OFS = 8'h08;
	localparam logic [1:0] CUR_OFF = 2'h0;
	localparam logic [1:0] CUR_SHORT = 2'h1;
	localparam logic [1:0] CUR_PRE = 2'h2;
	localparam logic [1:0] CUR_FAST = 2'h3;
	localparam logic [1:0] SCALE_100 = 2'h3;
	localparam logic [1:0] PHASE_IDLE = 2'h0;
	localparam logic [1:0] PHASE_PRE = 2'h1;
	localparam logic [1:0] PHASE_FAST = 2'h2;
	localparam logic [1:0] PHASE_DONE = 2'h3;
	localparam logic [1:0] FAULT_NONE = 2'h0;
	localparam logic [1:0] FAULT_TIMER = 2'h3;
	localparam logic [2:0] TS_NORMAL = 3'h0;
	localparam logic [2:0] TS_WARM = 3'h2;
	localparam logic [2:0] TS_COOL = 3'h3;
	localparam logic [2:0] TS_COLD = 3'h5;
	localparam logic [2:0] TS_HOT = 3'h6;

	typedef enum logic [2:0] {ST_IDLE, ST_CHARGE, ST_TOPOFF, ST_DONE, ST_TIMEOUT} charge_e;

	// comparator and pin levels, all asynchronous to clk_i
	typedef struct packed {
		logic above_2v2;
		logic above_3v;
		logic above_dplz;
		logic above_lowv;
		logic above_rechg;
		logic below_term;
		logic input_current_regulation;
		logic input_voltage_regulation;
		logic thermal_regulation;
		logic ts_cold;
		logic ts_cool;
		logic ts_warm;
		logic ts_hot;
		logic sense_connected;
		logic charge_enable_n;
		logic adapter;
		logic push_button_pin_n;
		logic battery_overvoltage;
	} pins_s;

	typedef struct packed {
		logic [1:0] current_select;
		logic [1:0] current_scale;
		logic vreg_warm;
		logic via_sense;
		logic battery_switch;
		logic hiz;
	} drive_s;

	typedef struct packed {
		logic thermistor_bypass;
		logic [1:0] topoff_setting;
		logic fast_timer_length;
		logic timer_slowdown_enable;
		logic timer_enable;
		logic term_enable;
		logic charge_enable_bit;
	} ctrl_s;

	typedef struct packed {
		logic reg_reset;
		logic high_impedance_enable;
		logic reset_with_input_bit;
		logic system_reset_enable;
		logic ship_with_input_bit;
		logic switch_off_delay_select;
		logic battery_switch_disable;
		logic remote_sense_disable;
		logic warm_voltage_select;
		logic [1:0] warm_current_scale;
		logic [1:0] cool_current_scale;
	} cfg_s;

	typedef struct packed {
		logic battery_switch;
		logic ship;
		logic via_sense;
		logic battery_overvoltage_flag;
		logic [1:0] charge_fault_code;
		logic [2:0] thermistor_fault_code;
		logic topoff_running_flag;
		logic [1:0] charge_phase_code;
	} status_s;

	localparam ctrl_s CTRL_DEF = 8'h0F;
	localparam cfg_s CFG_DEF = 13'h020D;

	typedef struct packed {
		pins_s sync1;
		pins_s sync2;
		pins_s prev;
		ctrl_s ctrl;
		cfg_s cfg;
		charge_e st;
		logic [TMR_W-1:0] safety_ms;
		logic [TMR_W-1:0] topoff_ms;
		logic [1:0] topoff_sel;
		logic half;
		logic [PRE_W-1:0] pre;
		logic [BTN_W-1:0] blink_ms;
		logic [BTN_W-1:0] btn_ms;
		logic [BTN_W-1:0] sw_ms;
		logic blink;
		logic btn_used;
		logic dis_q;
		logic dly_run;
		logic off_forced;
		logic ship;
		logic rst_busy;
		logic chg_en_q;
		logic sense_pending;
		logic [INT_W-1:0] int_cnt;
		logic int_n;
		drive_s drive;
		logic stat_oe;
		logic ack;
		logic [31:0] rdata;
	} state_s;
endpackage : charger_pkg

/* hdl/charge_cycle_controller.sv */
// module: charge sequencing, thermistor zones, safety timer and ship/reset control
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_controller #(
	parameter int unsigned MS_CYCLES = charger_pkg::MS_CYCLES_DEF,
	parameter int unsigned INT_CYCLES = charger_pkg::INT_CYCLES_DEF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [charger_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire charger_pkg::pins_s pins_i,
	output charger_pkg::drive_s drive_o,
	output logic stat_o,
	output logic stat_oe_o,
	output logic int_n_o
);
	charger_pkg::state_s s;
	charger_pkg::state_s n;
	charger_pkg::pins_s p;
	charger_pkg::status_s stw;
	logic ms;
	logic req;
	logic ev;
	logic enabled;
	logic stop;
	logic ts_bad;
	logic cool;
	logic warm;
	logic susp;
	logic dpm;
	logic slow;
	logic step;
	logic expired;
	logic term;
	logic rst_go;
	logic [charger_pkg::TMR_W-1:0] lim;

	// ************************************************************
	// helpers
	// ************************************************************
	// one timer advance: on a ms tick, not paused, every other tick when slowed
	function automatic logic timer_step(input logic tick, input logic pause, input logic slw,
		input logic ph);
		timer_step = tick & !pause & (!slw | ph);
	endfunction : timer_step

	function automatic logic [1:0] phase_of(input charger_pkg::charge_e st, input logic fast);
		case (st)
			charger_pkg::ST_CHARGE: phase_of = fast ? charger_pkg::PHASE_FAST : charger_pkg::PHASE_PRE;
			charger_pkg::ST_TOPOFF, charger_pkg::ST_DONE: phase_of = charger_pkg::PHASE_DONE;
			default: phase_of = charger_pkg::PHASE_IDLE;
		endcase
	endfunction : phase_of

	// ************************************************************
	// condition decode
	// ************************************************************
	assign p = s.sync2;
	assign enabled = s.ctrl.charge_enable_bit & !p.charge_enable_n;
	assign stop = !enabled | !p.adapter | s.cfg.battery_switch_disable | s.rst_busy;
	assign ts_bad = !s.ctrl.thermistor_bypass & (p.ts_cold | p.ts_hot);
	assign cool = !s.ctrl.thermistor_bypass & p.ts_cool;
	assign warm = !s.ctrl.thermistor_bypass & p.ts_warm;
	assign susp = ts_bad | p.battery_overvoltage;
	assign dpm = p.input_current_regulation | p.input_voltage_regulation | p.thermal_regulation;
	// half rate only when current really is below the setting
	assign slow = s.ctrl.timer_slowdown_enable & (dpm
		| (cool & s.cfg.cool_current_scale != charger_pkg::SCALE_100)
		| (warm & s.cfg.warm_current_scale != charger_pkg::SCALE_100));
	assign step = timer_step(ms, susp, slow, s.half);
	// 2 h below low-battery, otherwise 10 or 20 h
	assign lim = !p.above_lowv ? charger_pkg::SAFETY_LOW_MS
		: (s.ctrl.fast_timer_length ? charger_pkg::SAFETY_LONG_MS : charger_pkg::SAFETY_SHORT_MS);
	assign expired = s.ctrl.timer_enable & (s.safety_ms >= lim);
	// warm zone and regulation loops block termination
	assign term = s.st == charger_pkg::ST_CHARGE & !stop & !expired & p.above_rechg
		& p.below_term & s.ctrl.term_enable & !dpm & !warm & !susp;
	assign rst_go = !s.rst_busy & !s.btn_used & !p.push_button_pin_n
		& s.btn_ms >= charger_pkg::BUTTON_RESET_MS & s.cfg.system_reset_enable
		& !s.cfg.battery_switch_disable & (s.cfg.reset_with_input_bit | !p.adapter);

	always_comb begin
		stw.battery_switch = s.drive.battery_switch;
		stw.ship = s.ship;
		stw.via_sense = s.drive.via_sense;
		stw.battery_overvoltage_flag = p.battery_overvoltage;
		stw.charge_fault_code = s.st == charger_pkg::ST_TIMEOUT ? charger_pkg::FAULT_TIMER
			: charger_pkg::FAULT_NONE;
		if (s.ctrl.thermistor_bypass) begin
			stw.thermistor_fault_code = charger_pkg::TS_NORMAL;
		end else if (p.ts_cold) begin
			stw.thermistor_fault_code = charger_pkg::TS_COLD;
		end else if (p.ts_hot) begin
			stw.thermistor_fault_code = charger_pkg::TS_HOT;
		end else if (p.ts_cool) begin
			stw.thermistor_fault_code = charger_pkg::TS_COOL;
		end else if (p.ts_warm) begin
			stw.thermistor_fault_code = charger_pkg::TS_WARM;
		end else begin
			stw.thermistor_fault_code = charger_pkg::TS_NORMAL;
		end
		stw.topoff_running_flag = s.st == charger_pkg::ST_TOPOFF;
		stw.charge_phase_code = phase_of(s.st, p.above_3v);
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		n = s;
		ev = 1'b0;
		n.sync1 = pins_i;
		n.sync2 = s.sync1;
		n.prev = s.sync2;
		ms = s.pre == charger_pkg::PRE_W'(MS_CYCLES - 1);
		n.pre = ms ? '0 : s.pre + 1'b1;
		if (ms & slow) begin
			n.half = ~s.half;
		end

		// wishbone: ack one cycle after the request, write lands on the acked edge
		req = wb_cyc_i & wb_stb_i;
		n.ack = req & !s.ack;
		if (n.ack) begin
			case (wb_adr_i)
				charger_pkg::CTRL_OFS: n.rdata = {24'h000000, s.ctrl};
				charger_pkg::CFG_OFS: n.rdata = {19'h00000, s.cfg};
				charger_pkg::STATUS_OFS: n.rdata = {20'h00000, stw};
				default: n.rdata = 32'h00000000;
			endcase
		end
		if (req & s.ack & wb_we_i) begin
			if (wb_adr_i == charger_pkg::CTRL_OFS && wb_sel_i[0]) begin
				n.ctrl = wb_dat_i[7:0];
			end
			if (wb_adr_i == charger_pkg::CFG_OFS) begin
				if (wb_sel_i[0]) begin
					n.cfg[7:0] = wb_dat_i[7:0];
					if (!wb_dat_i[5] && p.above_dplz) begin
						n.sense_pending = 1'b1;
					end
				end
				if (wb_sel_i[1]) begin
					n.cfg[12:8] = wb_dat_i[12:8];
				end
			end
		end
		if (n.cfg.reg_reset) begin
			n.ctrl = charger_pkg::CTRL_DEF;
			n.cfg = charger_pkg::CFG_DEF;
		end

		// remote sense probe; hardware result wins over a same-cycle write
		if (!p.above_dplz) begin
			n.sense_pending = 1'b0;
		end else if (!s.prev.above_dplz) begin
			n.sense_pending = 1'b1;
		end else if (s.sense_pending) begin
			n.cfg.remote_sense_disable = !p.sense_connected;
			n.sense_pending = 1'b0;
		end

		// charge sequencer
		n.chg_en_q = enabled;
		if (stop && s.st != charger_pkg::ST_IDLE) begin
			n.st = charger_pkg::ST_IDLE;
		end else begin
			case (s.st)
				charger_pkg::ST_IDLE: begin
					if (!stop && !ts_bad) begin
						n.st = charger_pkg::ST_CHARGE;
						n.safety_ms = '0;
					end
				end
				charger_pkg::ST_CHARGE: begin
					if (expired) begin
						n.st = charger_pkg::ST_TIMEOUT;
						ev = 1'b1;
					end else if (term) begin
						ev = 1'b1;
						n.topoff_sel = s.ctrl.topoff_setting;
						n.topoff_ms = '0;
						n.st = s.ctrl.topoff_setting != 2'h0 ? charger_pkg::ST_TOPOFF
							: charger_pkg::ST_DONE;
					end else if (step) begin
						n.safety_ms = s.safety_ms + 1'b1;
					end
				end
				charger_pkg::ST_TOPOFF: begin
					if (!p.above_rechg) begin
						n.st = charger_pkg::ST_CHARGE;
						n.safety_ms = '0;
					end else if (s.ctrl.topoff_setting == 2'h0) begin
						n.st = charger_pkg::ST_DONE;
					end else if (s.topoff_ms >= topoff_limit(s.topoff_sel)) begin
						n.st = charger_pkg::ST_DONE;
						ev = 1'b1;
					end else if (step) begin
						n.topoff_ms = s.topoff_ms + 1'b1;
					end
				end
				charger_pkg::ST_DONE: begin
					if (!p.above_rechg) begin
						n.st = charger_pkg::ST_CHARGE;
						n.safety_ms = '0;
					end
				end
				charger_pkg::ST_TIMEOUT: begin
					n.st = charger_pkg::ST_TIMEOUT;
				end
				default: n.st = charger_pkg::ST_IDLE;
			endcase
		end
		// a fresh enable restarts the safety timer in every state
		if (enabled && !s.chg_en_q) begin
			n.safety_ms = '0;
		end

		// push-button low time in ms, saturating
		if (p.push_button_pin_n) begin
			n.btn_ms = '0;
			n.btn_used = 1'b0;
		end else if (ms && s.btn_ms != 16'hFFFF) begin
			n.btn_ms = s.btn_ms + 1'b1;
		end

		// ship mode exits
		if (s.ship && ((p.adapter && !s.prev.adapter)
			|| (!p.push_button_pin_n && s.btn_ms >= charger_pkg::SHIP_DEGLITCH_MS))) begin
			n.cfg.battery_switch_disable = 1'b0;
		end

		// switch disable with optional delay; with adapter present it waits for
		// the ship-with-input arming so supplement is not lost by accident
		n.dis_q = s.cfg.battery_switch_disable;
		if (!s.cfg.battery_switch_disable) begin
			n.off_forced = 1'b0;
			n.dly_run = 1'b0;
			n.ship = 1'b0;
		end else if (!s.dis_q) begin
			n.dly_run = 1'b1;
			n.sw_ms = s.cfg.switch_off_delay_select ? charger_pkg::SWITCH_DLY_MS : '0;
		end else if (s.dly_run) begin
			if (s.sw_ms == '0) begin
				if (!p.adapter || s.cfg.ship_with_input_bit) begin
					n.off_forced = 1'b1;
					n.dly_run = 1'b0;
				end
			end else if (ms) begin
				n.sw_ms = s.sw_ms - 1'b1;
			end
		end
		if (s.off_forced && !p.adapter && s.cfg.battery_switch_disable) begin
			n.ship = 1'b1;
		end

		// push-button system reset
		if (rst_go) begin
			n.rst_busy = 1'b1;
			n.btn_used = 1'b1;
			n.sw_ms = charger_pkg::RESET_OFF_MS;
		end else if (s.rst_busy) begin
			if (s.sw_ms == '0) begin
				n.rst_busy = 1'b0;
				n.st = charger_pkg::ST_IDLE;
				n.ctrl = charger_pkg::CTRL_DEF;
				n.cfg = charger_pkg::CFG_DEF;
				n.cfg.high_impedance_enable = s.cfg.high_impedance_enable;
			end else if (ms) begin
				n.sw_ms = s.sw_ms - 1'b1;
			end
		end

		// outputs, registered from the current state
		if (s.st == charger_pkg::ST_CHARGE && !susp) begin
			n.drive.current_select = !p.above_2v2 ? charger_pkg::CUR_SHORT
				: (!p.above_3v ? charger_pkg::CUR_PRE : charger_pkg::CUR_FAST);
		end else if (s.st == charger_pkg::ST_TOPOFF && !susp) begin
			n.drive.current_select = charger_pkg::CUR_FAST;
		end else begin
			n.drive.current_select = charger_pkg::CUR_OFF;
		end
		n.drive.current_scale = cool ? s.cfg.cool_current_scale
			: (warm ? s.cfg.warm_current_scale : charger_pkg::SCALE_100);
		n.drive.vreg_warm = warm & !s.cfg.warm_voltage_select;
		n.drive.via_sense = p.above_dplz & !s.cfg.remote_sense_disable & !s.sense_pending;
		n.drive.battery_switch = s.st != charger_pkg::ST_DONE & !s.off_forced & !s.rst_busy;
		n.drive.hiz = s.cfg.high_impedance_enable
			| (s.rst_busy & s.cfg.reset_with_input_bit);

		if (ms) begin
			if (s.blink_ms >= charger_pkg::BLINK_HALF_MS - 1'b1) begin
				n.blink_ms = '0;
				n.blink = ~s.blink;
			end else begin
				n.blink_ms = s.blink_ms + 1'b1;
			end
		end
		// pulled low while charging, released when done, blinks on suspend or timeout
		n.stat_oe = (s.st == charger_pkg::ST_CHARGE & !susp)
			| ((s.st == charger_pkg::ST_TIMEOUT | (s.st == charger_pkg::ST_CHARGE & susp))
			& s.blink);

		if (ev) begin
			n.int_cnt = charger_pkg::INT_W'(INT_CYCLES);
		end else if (s.int_cnt != '0) begin
			n.int_cnt = s.int_cnt - 1'b1;
		end
		n.int_n = n.int_cnt == '0;

		if (rst_i) begin
			n = '0;
			n.ctrl = charger_pkg::CTRL_DEF;
			n.cfg = charger_pkg::CFG_DEF;
			n.st = charger_pkg::ST_IDLE;
			n.int_n = 1'b1;
			// button idles high; a low reset value would look like a press
			n.sync1.push_button_pin_n = 1'b1;
			n.sync2.push_button_pin_n = 1'b1;
		end
	end

	// top-off limit: setting times the unit length
	function automatic logic [charger_pkg::TMR_W-1:0] topoff_limit(input logic [1:0] sel);
		topoff_limit = charger_pkg::TMR_W'(sel * charger_pkg::TOPOFF_UNIT_MS);
	endfunction : topoff_limit

	always_ff @(posedge clk_i) begin
		s <= n;
	end

	assign wb_ack_o = s.ack;
	assign wb_dat_o = s.rdata;
	assign drive_o = s.drive;
	assign stat_o = 1'b0;
	assign stat_oe_o = s.stat_oe;
	assign int_n_o = s.int_n;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	fast_current_a: assert property (
		s.st == charger_pkg::ST_CHARGE && !susp && p.above_3v
		|=> s.drive.current_select == charger_pkg::CUR_FAST)
		else $error("fast current not selected above 3 V");
	term_ends_a: assert property (
		term |=> (s.st == charger_pkg::ST_TOPOFF || s.st == charger_pkg::ST_DONE) && !s.int_n)
		else $error("termination did not end the cycle with a pulse");
	term_blocked_a: assert property (
		s.st == charger_pkg::ST_CHARGE && (dpm || warm)
		|=> s.st != charger_pkg::ST_TOPOFF && s.st != charger_pkg::ST_DONE)
		else $error("termination during regulation or warm zone");
	topoff_stop_a: assert property (
		s.st == charger_pkg::ST_TOPOFF && p.above_rechg && !stop
		&& s.ctrl.topoff_setting == 2'h0 |=> s.st == charger_pkg::ST_DONE)
		else $error("top-off not stopped by zero setting");
	bypass_code_a: assert property (
		s.ctrl.thermistor_bypass |-> stw.thermistor_fault_code == charger_pkg::TS_NORMAL && !ts_bad)
		else $error("thermistor fault shown while bypassed");
	timeout_pulse_a: assert property (
		$rose(s.st == charger_pkg::ST_TIMEOUT) |-> !s.int_n
		&& stw.charge_fault_code == charger_pkg::FAULT_TIMER)
		else $error("timer expiry without fault code or pulse");
	timer_pause_a: assert property (
		s.st == charger_pkg::ST_CHARGE && susp ##1 s.st == charger_pkg::ST_CHARGE
		|-> s.safety_ms == $past(s.safety_ms))
		else $error("safety timer ran during suspend");
	switch_off_a: assert property (
		$rose(s.off_forced) |=> !s.drive.battery_switch [*2])
		else $error("switch not off after disable");
	sense_low_a: assert property (
		!p.above_dplz |=> !s.drive.via_sense)
		else $error("remote sense used below depletion release");
	reset_off_a: assert property (
		rst_go |=> s.rst_busy ##1 !s.drive.battery_switch)
		else $error("button reset did not cycle the switch");

	term_seen_c: cover property (term ##1 s.st == charger_pkg::ST_TOPOFF);
	timeout_seen_c: cover property ($rose(s.st == charger_pkg::ST_TIMEOUT));
	ship_seen_c: cover property ($rose(s.ship));
	reset_seen_c: cover property ($fell(s.rst_busy));
endmodule : charge_cycle_controller
`default_nettype wire

/* verif/battery_model.sv */
// partner model: battery, thermistor and supply levels seen by the charger
`timescale 1ns/1ps
`default_nettype none
module battery_model #(
	parameter int DPLZ_MV = 2600,
	parameter int LOWV_MV = 3000,
	parameter int RECHG_MV = 4100
) (
	input wire logic [12:0] mv_i,
	input wire logic [3:0] ts_i,
	input wire logic [2:0] reg_i,
	input wire logic low_cur_i,
	input wire logic sense_i,
	output charger_pkg::pins_s pins_o
);
	always_comb begin
		pins_o = '0;
		pins_o.above_2v2 = mv_i > 13'h0898;
		pins_o.above_3v = mv_i > 13'h0BB8;
		pins_o.above_dplz = int'(mv_i) > DPLZ_MV;
		pins_o.above_lowv = int'(mv_i) > LOWV_MV;
		pins_o.above_rechg = int'(mv_i) > RECHG_MV;
		pins_o.below_term = low_cur_i;
		{pins_o.input_current_regulation, pins_o.input_voltage_regulation,
			pins_o.thermal_regulation} = reg_i;
		{pins_o.ts_cold, pins_o.ts_cool, pins_o.ts_warm, pins_o.ts_hot} = ts_i;
		pins_o.sense_connected = sense_i;
		pins_o.adapter = 1'b1;
		// button released: pulled up
		pins_o.push_button_pin_n = 1'b1;
	end
endmodule : battery_model
`default_nettype wire

/* verif/charge_cycle_controller_bench.sv */
// testbench: charge phases, zones, termination and registers over the bus
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_controller_bench;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, low = 0, sense = 0, wb_ack_o;
	logic stat_o, stat_oe_o, int_n_o;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0, q, wb_dat_o, seed = 32'h251D;
	logic [12:0] mv = 13'h0, m;
	logic [3:0] ts = 4'h0;
	logic [2:0] rg = 3'h0;
	logic [1:0] r;
	charger_pkg::drive_s drive_o;
	charger_pkg::pins_s pins;
	int n_errors = 0, compares = 0, cycles = 0, n;
	battery_model i_bat (.mv_i(mv), .ts_i(ts), .reg_i(rg), .low_cur_i(low), .sense_i(sense),
		.pins_o(pins));
	charge_cycle_controller #(.MS_CYCLES(10), .INT_CYCLES(8)) i_dut (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(4'hF),
		.wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.pins_i(pins), .drive_o(drive_o), .stat_o(stat_o), .stat_oe_o(stat_oe_o),
		.int_n_o(int_n_o));
	// ****************
	// helpers
	// ****************
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [1:0] exp_sel(input logic [12:0] v);
		return (v > 13'h0BB8) ? 2'h3 : (v > 13'h0898) ? 2'h2 : 2'h1;
	endfunction : exp_sel
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// request held to the edge that samples ack; data taken and request dropped there
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : bus
	// new charge cycle: disabled first so new levels cannot end the old cycle
	task automatic go(input logic [12:0] v, input logic [3:0] t, input logic [2:0] g,
		input logic l, input logic [7:0] c);
		bus(1'b1, 8'h00, {24'h0, c & 8'hFE});
		@(posedge clk_i);
		mv <= v;
		ts <= t;
		rg <= g;
		low <= l;
		bus(1'b1, 8'h00, {24'h0, c});
		repeat (10) @(posedge clk_i);
		bus(1'b0, 8'h08, 32'h0);
	endtask : go
	task automatic print_verdict();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : print_verdict
	initial begin
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			print_verdict();
		end
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, 8'h00, 32'h0);
		chk("ctrl", 32'h0F, q);
		bus(1'b0, 8'h04, 32'h0);
		chk("cfg", 32'h20D, q);
		bus(1'b0, 8'h0C, 32'h0);
		chk("unmapped", 32'h0, q);
		for (int i = 0; i < 7; i++) begin
			m = (i == 0) ? 13'h0834 : (i == 1) ? 13'h09C4 : (i == 2) ? 13'h0C1C :
				13'(32'h3E8 + xs() % 32'hD48);
			go(m, 4'h0, 3'h0, 1'b0, 8'h0F);
			chk("phase", {30'h0, (m > 13'h0BB8) ? 2'h2 : 2'h1}, {30'h0, q[1:0]});
			chk("select", {30'h0, exp_sel(m)}, {30'h0, drive_o.current_select});
		end
		go(13'h0DAC, 4'h0, 3'h0, 1'b0, 8'h0F);
		bus(1'b0, 8'h04, 32'h0);
		chk("sense off", 32'h1, {31'h0, q[5]});
		chk("via bat", 32'h0, {31'h0, drive_o.via_sense});
		sense <= 1'b1;
		bus(1'b1, 8'h04, 32'h20D);
		repeat (2) @(posedge clk_i);
		bus(1'b0, 8'h04, 32'h0);
		chk("sense on", 32'h0, {31'h0, q[5]});
		chk("via sense", 32'h1, {31'h0, drive_o.via_sense});
		for (int i = 0; i < 3; i++) begin
			r = 2'(xs() % 32'h4);
			bus(1'b1, 8'h04, 32'h20C | {30'h0, r});
			go(13'h0DAC, 4'h4, 3'h0, 1'b0, 8'h0F);
			chk("cool scale", {30'h0, r}, {30'h0, drive_o.current_scale});
			chk("cool code", 32'h3, {29'h0, q[5:3]});
		end
		bus(1'b1, 8'h04, 32'h20D);
		go(13'h0DAC, 4'h1, 3'h0, 1'b0, 8'h0F);
		chk("hot code", 32'h6, {29'h0, q[5:3]});
		chk("hot off", 32'h0, {30'h0, drive_o.current_select});
		go(13'h0DAC, 4'h1, 3'h0, 1'b0, 8'h8F);
		chk("bypass", 32'h0, {29'h0, q[5:3]});
		bus(1'b1, 8'h00, 32'h0F);
		repeat (3) @(posedge clk_i);
		chk("suspend", 32'h0, {30'h0, drive_o.current_select});
		go(13'h1068, 4'h0, 3'h0, 1'b1, 8'h0D);
		chk("no term", 32'h2, {30'h0, q[1:0]});
		bus(1'b1, 8'h04, 32'h30D);
		bus(1'b1, 8'h04, 32'h34D);
		repeat (5) @(posedge clk_i);
		bus(1'b0, 8'h08, 32'h0);
		chk("switch off", 32'h0, {30'h0, q[11:10]});
		bus(1'b1, 8'h04, 32'h20D);
		repeat (5) @(posedge clk_i);
		bus(1'b0, 8'h08, 32'h0);
		chk("switch on", 32'h1, {31'h0, q[11]});
		go(13'h1068, 4'h2, 3'h0, 1'b1, 8'h0F);
		chk("warm code", 32'h2, {29'h0, q[5:3]});
		chk("warm no term", 32'h2, {30'h0, q[1:0]});
		chk("warm volt", 32'h1, {31'h0, drive_o.vreg_warm});
		go(13'h1068, 4'h0, 3'h0, 1'b1, 8'h2F);
		chk("topoff", 32'h7, {29'h0, q[2:0]});
		chk("topoff stat", 32'h0, {31'h0, stat_oe_o});
		bus(1'b1, 8'h00, 32'h0F);
		bus(1'b0, 8'h08, 32'h0);
		chk("topoff stop", 32'h3, {29'h0, q[2:0]});
		go(13'h1068, 4'h0, 3'h4, 1'b1, 8'h0F);
		chk("regulating", 32'h2, {30'h0, q[1:0]});
		@(posedge clk_i);
		rg <= 3'h0;
		n = 0;
		while (int_n_o !== 1'b0 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		chk("int", 32'h0, {31'h0, int_n_o});
		bus(1'b0, 8'h08, 32'h0);
		chk("done", 32'h3, {30'h0, q[1:0]});
		chk("switch", 32'h0, {31'h0, drive_o.battery_switch});
		chk("stat", 32'h0, {31'h0, stat_oe_o});
		chk("stat pin", 32'h0, {31'h0, stat_o});
		chk("hiz", 32'h0, {31'h0, drive_o.hiz});
		print_verdict();
	end
endmodule : charge_cycle_controller_bench
`default_nettype wire
